// [hdl/sss_serial_port.sv]
// Synchronous slave serial port: register file, receive path with two-entry
// FIFO, transmit buffer and shift register, wake and interrupt requests.
// Assumes an external master drives the shift clock; clk_sys keeps running
// while the processor sleeps, and the core reports sleep on sleep_mode.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns

// Functional notes
// [R1] Slave receive follows continuous enable, ignores single
// [R2] Receive completes into FIFO during sleep too
// [R3] Receive flag with enable wakes processor
// [R4] Software sets up slave mode before enabling
// [R5] Receive flag on completion; request needs enable
// [R6] Software reads ninth bit before data
// [R7] Overrun cleared by continuous or port enable
// [R8] Only slave mode shifts; others stay stopped
// [R9] Shift registers timed only by clock pin
// [R10] Software drains receive data before sleep
// [R11] Sleeping device takes clocked word, flags it
// [R12] Wake resumes; global enable calls vector 004h
// [R13] Software fills transmit buffer before sleep
// [R14] Software sets transmit and peripheral enables
// [R15] Shift done: reload from buffer, set flag
// [R16] Writing transmit data clears transmit flag
// [R17] Clock and data pins relocatable by register
// [R18] Receive status bit layout, seven down zero
// [R19] Transmit status bit layout, seven down zero
// [R20] Baud control bit layout, 5 and 2 absent
// [R21] Receive flag bit 5, transmit bit 4
// [R22] Unimplemented bits read as zero
// [R23] Slave: sync set, master clear; receive enables
// [R24] Two-deep FIFO; third character raises overrun
// [R25] Nine-bit mode shifts nine bits, ninth MSB
// [R26] Polarity picks drive edge and sample edge
// [R27] Port disable resets shifters, FIFO, errors
module sss_serial_port
    import sss_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic sleep_mode,
    input wire logic ck_pri_in,
    input wire logic ck_alt_in,
    input wire logic dt_pri_in,
    input wire logic dt_alt_in,
    output logic dt_pri_out,
    output logic dt_pri_oe,
    output logic dt_alt_out,
    output logic dt_alt_oe,
    output logic wake_request,
    output logic isr_call,
    output logic [11:0] isr_vector_addr
);
    logic [DATA_W-1:0] rcs_reg;
    logic [DATA_W-1:0] txs_reg;
    logic [DATA_W-1:0] bdc_reg;
    logic [DATA_W-1:0] pie_reg;
    logic [DATA_W-1:0] pir_sw_reg;
    logic [DATA_W-1:0] gic_reg;
    logic [DATA_W-1:0] alt_reg;
    logic [DATA_W-1:0] ans_reg;

    logic [3:0] pin_sync;
    logic ck_now;
    logic dt_now;
    logic ck_prev_reg;
    logic ck_rise;
    logic ck_fall;
    logic lead_edge;
    logic trail_edge;

    logic port_en;
    logic slave_mode;
    logic rx_mode;
    logic tx_mode;

    logic [WORD_W-1:0] rsr_reg;
    logic [CNT_W-1:0] rx_cnt_reg;
    logic [CNT_W-1:0] rx_last;
    logic rx_done;
    logic [WORD_W-1:0] rx_word;

    logic [WORD_W-1:0] fifo_mem [0:1];
    logic fifo_wr_ptr_reg;
    logic fifo_rd_ptr_reg;
    logic [1:0] fifo_cnt_reg;
    logic [WORD_W-1:0] fifo_head;
    logic fifo_pop;
    logic fifo_push;
    logic overrun_reg;

    sss_tx_state_e tx_state_reg;
    logic [WORD_W-1:0] tx_buf_reg;
    logic tx_buf_full_reg;
    logic [WORD_W-1:0] tsr_reg;
    logic [CNT_W-1:0] tx_cnt_reg;
    logic [CNT_W-1:0] tx_last;
    logic tx_wr;

    logic rx_flag;
    logic tx_flag;
    logic rx_pending;
    logic tx_pending;

    // Pins pass two flops before anything looks at them
    sss_pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in({dt_alt_in, dt_pri_in, ck_alt_in, ck_pri_in}),
        .pin_sync(pin_sync)
    );

    // Pin location and analog gating; an analog pin reads as low
    always_comb begin
        ck_now = alt_reg[ALT_PIN_SEL] ? pin_sync[1] : pin_sync[0]; // [R17]
        dt_now = alt_reg[ALT_PIN_SEL] ? pin_sync[3] : pin_sync[2]; // [R17]
        if (ans_reg[ANS_CLK_PIN]) begin
            ck_now = 1'b0;
        end
        if (ans_reg[ANS_DATA_PIN]) begin
            dt_now = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ck_prev_reg <= 1'b0;
        end else begin
            ck_prev_reg <= ck_now;
        end
    end

    // The external clock alone times both shifters; clk_sys only samples it
    assign ck_rise = ck_now & ~ck_prev_reg; // [R9]
    assign ck_fall = ~ck_now & ck_prev_reg; // [R9]
    // Idle level follows polarity: leading edge samples, trailing edge drives
    assign lead_edge = bdc_reg[BDC_CLK_POL] ? ck_fall : ck_rise; // [R26]
    assign trail_edge = bdc_reg[BDC_CLK_POL] ? ck_rise : ck_fall; // [R26]

    assign port_en = rcs_reg[RCS_PORT_EN];
    // Master mode is not built, so nothing but slave mode ever shifts
    assign slave_mode = port_en & txs_reg[TXS_SYNC_MODE] & ~txs_reg[TXS_CLK_MASTER]; // [R23] [R8]
    assign rx_mode = slave_mode & rcs_reg[RCS_CONT_RX]; // [R1]
    assign tx_mode = slave_mode & ~rcs_reg[RCS_CONT_RX] & ~rcs_reg[RCS_SINGLE_RX]
                     & txs_reg[TXS_TX_EN]; // [R23]

    // Register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rcs_reg <= RCS_RESET;
            txs_reg <= TXS_RESET;
            bdc_reg <= BDC_RESET;
            pie_reg <= PIE_RESET;
            pir_sw_reg <= PIR_RESET;
            gic_reg <= GIC_RESET;
            alt_reg <= ALT_RESET;
            ans_reg <= ANS_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ADDR_RCV_STAT: rcs_reg <= reg_wdata & RCS_WR_MASK; // [R18]
                ADDR_XMT_STAT: txs_reg <= reg_wdata & TXS_WR_MASK; // [R19]
                ADDR_BAUD_CTRL: bdc_reg <= reg_wdata & BDC_WR_MASK; // [R20]
                ADDR_PERIPH_IE: pie_reg <= reg_wdata & PIR_IMPL_MASK; // [R21]
                ADDR_PERIPH_IF: pir_sw_reg <= reg_wdata & PIR_SW_MASK;
                ADDR_GLOBAL_INT: gic_reg <= reg_wdata;
                ADDR_ALT_PIN: alt_reg <= reg_wdata & ALT_WR_MASK; // [R17]
                ADDR_ANALOG_SEL: ans_reg <= reg_wdata & ANS_WR_MASK;
                default: ;
            endcase
        end
    end

    assign tx_wr = reg_wr && (reg_addr == ADDR_XMT_DATA);
    assign fifo_pop = reg_rd && (reg_addr == ADDR_RCV_DATA) && (fifo_cnt_reg != 2'h0);

    // Receive shifter; stalls while overrun stands
    assign rx_last = rcs_reg[RCS_RX9_SEL] ? LAST_BIT_9 : LAST_BIT_8; // [R25]
    assign rx_done = rx_mode && lead_edge && !overrun_reg && (rx_cnt_reg == rx_last); // [R11]
    always_comb begin
        if (rcs_reg[RCS_RX9_SEL]) begin
            rx_word = {dt_now, rsr_reg[WORD_W-1:1]}; // [R25]
        end else begin
            rx_word = {1'b0, dt_now, rsr_reg[WORD_W-1:2]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !port_en) begin
            rsr_reg <= '0; // [R27]
            rx_cnt_reg <= '0;
        end else if (!rx_mode) begin
            rx_cnt_reg <= '0;
        end else if (lead_edge && !overrun_reg) begin
            rsr_reg <= {dt_now, rsr_reg[WORD_W-1:1]};
            if (rx_cnt_reg == rx_last) begin
                rx_cnt_reg <= '0;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
            end
        end
    end

    // Two-entry receive FIFO; a read in the same cycle makes room
    assign fifo_push = rx_done && ((fifo_cnt_reg != FIFO_DEPTH) || fifo_pop); // [R2] [R24]
    assign fifo_head = fifo_mem[fifo_rd_ptr_reg];

    always_ff @(posedge clk_sys) begin
        if (rst || !port_en) begin
            fifo_mem[0] <= '0; // [R27]
            fifo_mem[1] <= '0;
            fifo_wr_ptr_reg <= 1'b0;
            fifo_rd_ptr_reg <= 1'b0;
            fifo_cnt_reg <= 2'h0;
        end else begin
            if (fifo_push) begin
                fifo_mem[fifo_wr_ptr_reg] <= rx_word;
                fifo_wr_ptr_reg <= ~fifo_wr_ptr_reg;
            end
            if (fifo_pop) begin
                fifo_rd_ptr_reg <= ~fifo_rd_ptr_reg;
            end
            if (fifo_push && !fifo_pop) begin
                fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
            end else if (fifo_pop && !fifo_push) begin
                fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
            end
        end
    end

    // Overrun keeps the FIFO intact; only dropping continuous or port enable clears it
    always_ff @(posedge clk_sys) begin
        if (rst || !port_en) begin
            overrun_reg <= 1'b0; // [R7] [R27]
        end else if (rx_done && (fifo_cnt_reg == FIFO_DEPTH) && !fifo_pop) begin
            overrun_reg <= 1'b1; // [R24]
        end else if (!rcs_reg[RCS_CONT_RX]) begin
            overrun_reg <= 1'b0; // [R7]
        end
    end

    // Transmit buffer and shift register
    assign tx_last = txs_reg[TXS_TX9_SEL] ? LAST_BIT_9 : LAST_BIT_8;

    always_ff @(posedge clk_sys) begin
        if (rst || !port_en) begin
            tx_state_reg <= SSS_TX_IDLE; // [R27]
            tx_buf_reg <= '0;
            tx_buf_full_reg <= 1'b0;
            tsr_reg <= '0;
            tx_cnt_reg <= '0;
        end else begin
            if (tx_wr) begin
                tx_buf_reg <= {txs_reg[TXS_TX_BIT9], reg_wdata};
                tx_buf_full_reg <= 1'b1; // [R16]
            end
            unique case (tx_state_reg)
                SSS_TX_IDLE: begin
                    // An empty shifter takes the character at once
                    if (tx_mode && tx_buf_full_reg) begin
                        tsr_reg <= tx_buf_reg;
                        tx_buf_full_reg <= tx_wr;
                        tx_cnt_reg <= '0;
                        tx_state_reg <= SSS_TX_SHIFT;
                    end
                end
                SSS_TX_SHIFT: begin
                    if (!tx_mode) begin
                        tx_state_reg <= SSS_TX_IDLE;
                    end else if (trail_edge) begin
                        if (tx_cnt_reg != tx_last) begin
                            tsr_reg <= tsr_reg >> 1;
                            tx_cnt_reg <= tx_cnt_reg + 4'h1;
                        end else if (tx_buf_full_reg) begin
                            tsr_reg <= tx_buf_reg; // [R15]
                            tx_buf_full_reg <= tx_wr;
                            tx_cnt_reg <= '0;
                        end else begin
                            tx_state_reg <= SSS_TX_IDLE;
                        end
                    end
                end
                default: tx_state_reg <= SSS_TX_IDLE;
            endcase
        end
    end

    // The data pin is driven only while a character is shifting out
    always_comb begin
        dt_pri_out = tsr_reg[0];
        dt_alt_out = tsr_reg[0];
        dt_pri_oe = (tx_state_reg == SSS_TX_SHIFT) && !alt_reg[ALT_PIN_SEL]; // [R17]
        dt_alt_oe = (tx_state_reg == SSS_TX_SHIFT) && alt_reg[ALT_PIN_SEL];
    end

    // Flags follow buffer state, so an event never loses to a clear
    assign rx_flag = (fifo_cnt_reg != 2'h0); // [R5]
    assign tx_flag = !tx_buf_full_reg; // [R15] [R16]
    assign rx_pending = rx_flag && pie_reg[PIR_RX_FLAG]; // [R3] [R5]
    assign tx_pending = tx_flag && pie_reg[PIR_TX_FLAG] && gic_reg[GIC_PERIPH_EN];

    // Wake only while asleep; the vector call also needs the global enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wake_request <= 1'b0;
            isr_call <= 1'b0;
            isr_vector_addr <= ISR_VECTOR;
        end else begin
            wake_request <= sleep_mode && (rx_pending || tx_pending); // [R3] [R11]
            isr_call <= gic_reg[GIC_GLOBAL_EN] && (rx_pending || tx_pending); // [R12]
            isr_vector_addr <= ISR_VECTOR; // [R12]
        end
    end

    // Read data stand one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_RCV_STAT: reg_rdata <= {rcs_reg[7:3], 1'b0, overrun_reg,
                                             fifo_head[WORD_W-1]}; // [R18] [R22]
                ADDR_XMT_STAT: reg_rdata <= {txs_reg[7:2],
                                             tx_state_reg == SSS_TX_IDLE,
                                             txs_reg[TXS_TX_BIT9]}; // [R19]
                ADDR_BAUD_CTRL: reg_rdata <= {bdc_reg[7], !rx_mode, 1'b0, bdc_reg[4:3],
                                              1'b0, bdc_reg[1:0]}; // [R20] [R22]
                ADDR_RCV_DATA: reg_rdata <= fifo_head[DATA_W-1:0];
                ADDR_PERIPH_IE: reg_rdata <= pie_reg;
                ADDR_PERIPH_IF: reg_rdata <= {pir_sw_reg[7:6], rx_flag, tx_flag,
                                              pir_sw_reg[3:0]}; // [R21]
                ADDR_GLOBAL_INT: reg_rdata <= gic_reg;
                ADDR_ALT_PIN: reg_rdata <= alt_reg;
                ADDR_ANALOG_SEL: reg_rdata <= ans_reg;
                default: reg_rdata <= '0; // [R22]
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule

// [hdl/sss_pkg.sv]
// Package for the synchronous slave serial port: register map, field positions,
// reset values, write masks and character sizes.
// Assumes one system clock domain; the shift clock arrives on a pin and is sampled.
package sss_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int WORD_W = 9;
    localparam int CNT_W = 4;

    // Register offsets on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_RCV_STAT = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_XMT_STAT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_BAUD_CTRL = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_RCV_DATA = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_XMT_DATA = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PERIPH_IE = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_PERIPH_IF = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL_INT = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_ALT_PIN = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_ANALOG_SEL = 4'h9;

    // receive_status_control fields
    localparam int RCS_PORT_EN = 7;
    localparam int RCS_RX9_SEL = 6;
    localparam int RCS_SINGLE_RX = 5;
    localparam int RCS_CONT_RX = 4;
    localparam int RCS_ADDR_DET = 3;
    localparam int RCS_FRAME_ERR = 2;
    localparam int RCS_OVERRUN = 1;
    localparam int RCS_RX_BIT9 = 0;
    localparam logic [DATA_W-1:0] RCS_WR_MASK = 8'hF8;

    // transmit_status_control fields
    localparam int TXS_CLK_MASTER = 7;
    localparam int TXS_TX9_SEL = 6;
    localparam int TXS_TX_EN = 5;
    localparam int TXS_SYNC_MODE = 4;
    localparam int TXS_SEND_BREAK = 3;
    localparam int TXS_HIGH_BAUD = 2;
    localparam int TXS_SHIFT_EMPTY = 1;
    localparam int TXS_TX_BIT9 = 0;
    localparam logic [DATA_W-1:0] TXS_WR_MASK = 8'hFD;

    // baud_control fields; bits 5 and 2 do not exist
    localparam int BDC_AB_OVF = 7;
    localparam int BDC_RX_IDLE = 6;
    localparam int BDC_CLK_POL = 4;
    localparam int BDC_WIDE_BRG = 3;
    localparam int BDC_WAKE_EDGE = 1;
    localparam int BDC_AUTO_BAUD = 0;
    localparam logic [DATA_W-1:0] BDC_WR_MASK = 8'h9B;

    // Peripheral flag/enable positions; bit 2 does not exist
    localparam int PIR_RX_FLAG = 5;
    localparam int PIR_TX_FLAG = 4;
    localparam logic [DATA_W-1:0] PIR_IMPL_MASK = 8'hFB;
    localparam logic [DATA_W-1:0] PIR_SW_MASK = 8'hCB;

    // global_interrupt_control fields
    localparam int GIC_GLOBAL_EN = 7;
    localparam int GIC_PERIPH_EN = 6;

    localparam int ALT_PIN_SEL = 0;
    localparam int ANS_CLK_PIN = 0;
    localparam int ANS_DATA_PIN = 1;
    localparam logic [DATA_W-1:0] ALT_WR_MASK = 8'h01;
    localparam logic [DATA_W-1:0] ANS_WR_MASK = 8'h03;

    // Reset values
    localparam logic [DATA_W-1:0] RCS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] TXS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] BDC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PIE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PIR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] GIC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ALT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ANS_RESET = 8'h03;

    // Last bit index of a character, 8-bit and 9-bit
    localparam logic [CNT_W-1:0] LAST_BIT_8 = 4'h7;
    localparam logic [CNT_W-1:0] LAST_BIT_9 = 4'h8;

    localparam logic [1:0] FIFO_DEPTH = 2'h2;
    localparam logic [11:0] ISR_VECTOR = 12'h004;

    typedef enum logic [1:0] {
        SSS_TX_IDLE = 2'b01,
        SSS_TX_SHIFT = 2'b10
    } sss_tx_state_e;

endpackage

// [hdl/sss_pin_sync.sv]
// Two-flop synchroniser for the serial port's pin inputs.
// Assumes the pins are asynchronous to clk_sys; output lags the pin by two edges.
`timescale 1ns/1ns
module sss_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_reg;

    // The first stage feeds the second stage only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_reg <= '0;
            pin_sync <= '0;
        end else begin
            meta_reg <= pin_in;
            pin_sync <= meta_reg;
        end
    end
endmodule

// [testbench/sss_sync_master.sv]
// Model of the external master: drives the shift clock, swaps characters LSB first.
// Assumes the bench resolves the data wire from this drive and the port's own drive.
`timescale 1ns/1ns
module sss_sync_master (
    input wire logic pol,
    input wire logic dt_in,
    output logic ck,
    output logic dt_drv
);
    logic phase = 1'b0;
    assign ck = phase ^ pol;
    initial dt_drv = 1'b1;
    // 32 ns link clock, only within frames; idle level set by polarity
    task automatic xfer(input logic [8:0] d, input int n, output logic [8:0] q);
        q = 9'h000;
        #1;
        for (int i = 0; i < n; i++) begin
            dt_drv = d[i];
            #16;
            phase = 1'b1;
            q[i] = dt_in;
            #16;
            phase = 1'b0;
        end
        // Released line shows the inverse so a stale bit cannot pass
        dt_drv = ~dt_drv;
        #64;
    endtask
endmodule

// [testbench/sss_serial_port_properties.sv]
// Checker for the slave serial port, bound to its top module.
// Sees only the top ports; control bits are shadowed from register writes.
`timescale 1ns/1ns
module sss_serial_port_properties
    import sss_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic sleep_mode,
    input wire logic dt_pri_oe,
    input wire logic dt_alt_oe,
    input wire logic wake_request,
    input wire logic isr_call,
    input wire logic [11:0] isr_vector_addr
);
    logic gie_reg;
    logic cont_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gie_reg <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_GLOBAL_INT) begin
            gie_reg <= reg_wdata[GIC_GLOBAL_EN];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cont_reg <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_RCV_STAT) begin
            cont_reg <= reg_wdata[RCS_CONT_RX];
        end
    end

    sequence s_rd_at(logic [ADDR_W-1:0] a);
        reg_rd && reg_addr == a;
    endsequence

    sequence s_port_off;
        reg_wr && reg_addr == ADDR_RCV_STAT && !reg_wdata[RCS_PORT_EN];
    endsequence

    a_vector_fixed: assert property (!$past(rst) |-> isr_vector_addr == ISR_VECTOR)
        else $error("interrupt vector address wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_ANALOG_SEL |=> !reg_rdata)
        else $error("unmapped read not zero");
    a_txdata_reads_zero: assert property (s_rd_at(ADDR_XMT_DATA) |=> reg_rdata == 8'h00)
        else $error("transmit data readable");
    a_wake_needs_sleep: assert property (!sleep_mode |=> !wake_request)
        else $error("wake request while awake");
    a_one_data_pin: assert property (!(dt_pri_oe && dt_alt_oe))
        else $error("both data pins driven");
    a_rx_no_drive: assert property (cont_reg && $past(cont_reg) |-> !dt_pri_oe && !dt_alt_oe)
        else $error("data pin driven in receive mode");
    a_isr_needs_gie: assert property (!gie_reg |=> !isr_call)
        else $error("service call without global enable");
    a_port_off_idle: assert property (s_port_off |-> ##3 !dt_pri_oe && !dt_alt_oe)
        else $error("data pin driven after port disable");
endmodule

bind sss_serial_port sss_serial_port_properties i_props (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .dt_pri_oe(dt_pri_oe), .dt_alt_oe(dt_alt_oe), .wake_request(wake_request),
    .isr_call(isr_call), .isr_vector_addr(isr_vector_addr)
);

// [testbench/tb.sv]
// Self-checking bench for the slave serial port.
// Assumes the master model owns the link clock; unselected pins idle.
`timescale 1ns/1ns
module tb
    import sss_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic sleep_mode = 1'b0;
    logic alt_sel = 1'b0, pol = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic dt_pri_out, dt_pri_oe, dt_alt_out, dt_alt_oe;
    logic wake_request, isr_call, m_ck, m_dt, dt_line;
    logic [11:0] isr_vector_addr;
    logic [8:0] q;
    int errors = 0, n_tests = 0;

    always #2 clk_sys = ~clk_sys;
    assign dt_line = alt_sel ? (dt_alt_oe ? dt_alt_out : m_dt)
                             : (dt_pri_oe ? dt_pri_out : m_dt);

    sss_serial_port i_dut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
        .ck_pri_in(alt_sel ? pol : m_ck), .ck_alt_in(alt_sel ? m_ck : pol),
        .dt_pri_in(alt_sel ? 1'b1 : dt_line), .dt_alt_in(alt_sel ? dt_line : 1'b1),
        .dt_pri_out(dt_pri_out), .dt_pri_oe(dt_pri_oe), .dt_alt_out(dt_alt_out),
        .dt_alt_oe(dt_alt_oe), .wake_request(wake_request), .isr_call(isr_call),
        .isr_vector_addr(isr_vector_addr)
    );
    sss_sync_master i_master (.pol(pol), .dt_in(dt_line), .ck(m_ck), .dt_drv(m_dt));

    task automatic report_and_stop();
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task automatic rbit(input logic [ADDR_W-1:0] a, input int b, input logic e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk({7'h00, reg_rdata[b]}, {7'h00, e});
    endtask

    task automatic cfg(input logic [7:0] rcs, input logic [7:0] txs);
        wr(ADDR_XMT_STAT, txs);
        wr(ADDR_RCV_STAT, rcs);
    endtask

    // Flag lands ~4 clocks after the last edge; eight leave margin
    task automatic send(input logic [8:0] c, input int n);
        i_master.xfer(c, n, q);
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_regs();
        rchk(ADDR_RCV_STAT, RCS_RESET);
        rchk(ADDR_ANALOG_SEL, ANS_RESET);
        rchk(4'hF, 8'h00);
        wr(ADDR_BAUD_CTRL, 8'hFF);
        rchk(ADDR_BAUD_CTRL, 8'hDB);
        wr(ADDR_BAUD_CTRL, 8'h00);
        wr(ADDR_XMT_STAT, 8'hF5);
        rchk(ADDR_XMT_STAT, 8'hF7);
        rchk(ADDR_XMT_DATA, 8'h00);
        rbit(ADDR_PERIPH_IF, PIR_TX_FLAG, 1'b1);
        wr(ADDR_ANALOG_SEL, 8'h00);
    endtask

    task automatic t_sleep_rx();
        cfg(8'h90, 8'h10);
        wr(ADDR_PERIPH_IE, 8'h20);
        sleep_mode <= 1'b1;
        send(9'h0A5, 8);
        chk({7'h00, wake_request}, 8'h01);
        chk({7'h00, isr_call}, 8'h00);
        wr(ADDR_GLOBAL_INT, 8'h80);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({7'h00, isr_call}, 8'h01);
        chk(isr_vector_addr[7:0], 8'h04);
        sleep_mode <= 1'b0;
        rchk(ADDR_RCV_DATA, 8'hA5);
        rbit(ADDR_PERIPH_IF, PIR_RX_FLAG, 1'b0);
        wr(ADDR_GLOBAL_INT, 8'h00);
        wr(ADDR_PERIPH_IE, 8'h00);
        sleep_mode <= 1'b1;
        send(9'h03C, 8);
        chk({7'h00, wake_request}, 8'h00);
        rbit(ADDR_PERIPH_IF, PIR_RX_FLAG, 1'b1);
        sleep_mode <= 1'b0;
        rchk(ADDR_RCV_DATA, 8'h3C);
    endtask

    task automatic t_no_rx();
        logic [7:0] rcs [3] = '{8'hA0, 8'h90, 8'hB0};
        logic [7:0] txs [3] = '{8'h10, 8'h90, 8'h10};
        for (int k = 0; k < 3; k++) begin
            cfg(rcs[k], txs[k]);
            send(9'h055, 8);
            rbit(ADDR_PERIPH_IF, PIR_RX_FLAG, k == 2);
        end
        rchk(ADDR_RCV_DATA, 8'h55);
    endtask

    task automatic t_overrun();
        cfg(8'h90, 8'h10);
        send(9'h001, 8);
        send(9'h002, 8);
        send(9'h003, 8);
        rbit(ADDR_RCV_STAT, RCS_OVERRUN, 1'b1);
        rchk(ADDR_RCV_DATA, 8'h01);
        rchk(ADDR_RCV_DATA, 8'h02);
        send(9'h004, 8);
        rbit(ADDR_PERIPH_IF, PIR_RX_FLAG, 1'b0);
        wr(ADDR_RCV_STAT, 8'h80);
        wr(ADDR_RCV_STAT, 8'h90);
        rbit(ADDR_RCV_STAT, RCS_OVERRUN, 1'b0);
        send(9'h005, 8);
        wr(ADDR_RCV_STAT, 8'h10);
        wr(ADDR_RCV_STAT, 8'h90);
        rbit(ADDR_PERIPH_IF, PIR_RX_FLAG, 1'b0);
        send(9'h006, 8);
        rchk(ADDR_RCV_DATA, 8'h06);
    endtask

    task automatic t_nine();
        cfg(8'hD0, 8'h10);
        send(9'h1C3, 9);
        rbit(ADDR_RCV_STAT, RCS_RX_BIT9, 1'b1);
        rchk(ADDR_RCV_DATA, 8'hC3);
        send(9'h03C, 9);
        rbit(ADDR_RCV_STAT, RCS_RX_BIT9, 1'b0);
        rchk(ADDR_RCV_DATA, 8'h3C);
    endtask

    // Port held off while pins and polarity move, so no stray edge is taken
    task automatic t_alt();
        wr(ADDR_RCV_STAT, 8'h00);
        wr(ADDR_ALT_PIN, 8'h01);
        wr(ADDR_BAUD_CTRL, 8'h10);
        pol <= 1'b1;
        alt_sel <= 1'b1;
        wr(ADDR_RCV_STAT, 8'h90);
        send(9'h069, 8);
        rchk(ADDR_RCV_DATA, 8'h69);
        wr(ADDR_RCV_STAT, 8'h00);
        wr(ADDR_ALT_PIN, 8'h00);
        wr(ADDR_BAUD_CTRL, 8'h00);
        pol <= 1'b0;
        alt_sel <= 1'b0;
    endtask

    task automatic t_tx();
        cfg(8'h80, 8'h30);
        wr(ADDR_PERIPH_IE, 8'h10);
        wr(ADDR_GLOBAL_INT, 8'h40);
        wr(ADDR_XMT_DATA, 8'h5A);
        wr(ADDR_XMT_DATA, 8'h96);
        rbit(ADDR_PERIPH_IF, PIR_TX_FLAG, 1'b0);
        sleep_mode <= 1'b1;
        chk({7'h00, dt_pri_oe}, 8'h01);
        send(9'h000, 8);
        chk(q[7:0], 8'h5A);
        chk({7'h00, wake_request}, 8'h01);
        rbit(ADDR_PERIPH_IF, PIR_TX_FLAG, 1'b1);
        wr(ADDR_ALT_PIN, 8'h01);
        alt_sel <= 1'b1;
        send(9'h000, 8);
        chk(q[7:0], 8'h96);
        chk({6'h00, dt_alt_oe, dt_pri_oe}, 8'h00);
        sleep_mode <= 1'b0;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_sleep_rx();
        t_no_rx();
        t_overrun();
        t_nine();
        t_alt();
        t_tx();
        report_and_stop();
    end

    // Sixteen characters of 400 ns each; 100 us is ample
    initial begin
        #100000;
        errors++;
        report_and_stop();
    end
endmodule
